// >>> core/bus_cycle_defines.vh
// constants used by the bus cycle unit and for sizing its fifo
// assumes a single 100 mhz clock and a 20-bit physical address
`ifndef BUS_CYCLE_DEFINES_VH
`define BUS_CYCLE_DEFINES_VH

// ****************************************************************
// widths and depths
// ****************************************************************
`define ADDR_W 20
`define DATA_W 16
`define REQ_FIFO_DEPTH 32
`define REQ_FIFO_AW 5
// write, io, word, vector, address, data
`define REQ_W 40

// ****************************************************************
// prefetch queue sizes in bytes
// ****************************************************************
`define QUEUE_NARROW 3'h4
`define QUEUE_WIDE 3'h6

// ****************************************************************
// address space constants
// ****************************************************************
`define IO_ADDR_MASK 20'h0_ffff
`define ADDR_STEP 20'h0_0001

`endif

// >>> core/req_fifo.v
// request fifo between execution side and the bus sequencer
// assumes one clock, synchronous active-low reset
module req_fifo #(
  parameter WIDTH = 40,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clock,
  input wire rstn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_reg;
  reg [AW:0] rd_ptr_reg;
  wire full;
  wire empty;
  wire push;
  wire pop;

  // ****************************************************************
  // pointers carry one extra wrap bit so full and empty are exact
  // ****************************************************************
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
    (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];

  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clock) begin
    if (!rstn) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

endmodule // req_fifo

// >>> core/lane_steer.v
// byte lane steering for one bus cycle: lane selects and write lanes
// purely combinational; the sequencer registers its outputs at the first state
module lane_steer (
  input wire wide_bus,
  input wire cycle_a0,
  input wire word,
  input wire second,
  input wire [15:0] wdata,
  output reg upper_lane_select_n,
  output reg [15:0] lane_data,
  output reg split
);

  always @* begin
    upper_lane_select_n = 1'b1;
    lane_data = 16'h0000;
    split = 1'b0;
    if (!wide_bus) begin
      // narrow lanes: one byte per cycle, any word takes two
      split = word;
      lane_data = {8'h00, second ? wdata[15:8] : wdata[7:0]};
    end else if (word && !cycle_a0 && !second) begin
      upper_lane_select_n = 1'b0;
      lane_data = wdata;
    end else if (word && !second) begin
      // odd word, first half: low byte rides the high lane
      split = 1'b1;
      upper_lane_select_n = 1'b0;
      lane_data = {wdata[7:0], 8'h00};
    end else if (word) begin
      split = 1'b1;
      upper_lane_select_n = 1'b1;
      lane_data = {8'h00, wdata[15:8]};
    end else if (cycle_a0) begin
      upper_lane_select_n = 1'b0;
      lane_data = {wdata[7:0], 8'h00};
    end else begin
      upper_lane_select_n = 1'b1;
      lane_data = {8'h00, wdata[7:0]};
    end
  end

endmodule // lane_steer

// >>> core/bus_unit.v
// bus control unit: request fifo, prefetch queue and six-state sequencer
// assumes the external bus and the execution side share this clock
// Summary of operation
// - narrow bus: one byte per cycle, words two
// - low bank by bit zero, high by select
// - address bits 19..1 give location in bank
// - even word: both lanes, one cycle
// - odd word: high lane, then address+1 low
// - even byte: low lane, select high
// - odd byte: high lane, select low
// - word prefetch; odd branch fetches one byte
// - vector table reads even, one word each
// - each access is four bus states
// - io uses low 16 address lines
// - io has no segment; top lines zero
// - io even word one cycle, odd two
// - prefetch while queue has room
// - idle states while queue full and busy
// - ready low inserts wait before fourth state
// - outputs hold during wait states
// - memory-mapped io uses memory strobes
// - queue holds four or six bytes
// - prefetch needs free byte or free word
`include "bus_cycle_defines.vh"

module bus_unit (
  input wire clock,
  input wire rstn,
  input wire wide_bus,
  input wire req_valid,
  output wire req_ready,
  input wire req_write,
  input wire req_io,
  input wire req_word,
  input wire req_vector,
  input wire [19:0] req_addr,
  input wire [15:0] req_wdata,
  output reg rsp_valid,
  output reg [15:0] rsp_data,
  input wire branch_valid,
  input wire [19:0] branch_addr,
  output wire [7:0] q_byte,
  output wire q_valid,
  input wire q_take,
  output wire [19:1] bus_addr,
  output wire address_bit_zero,
  output reg upper_lane_select_n,
  output reg [15:0] data_out,
  output reg data_oe,
  input wire [15:0] data_in,
  output reg ale,
  output reg rd_n,
  output reg wr_n,
  output reg io_cycle,
  input wire ready,
  output wire first_bus_state,
  output wire fourth_bus_state,
  output wire bus_wait_state,
  output wire bus_idle_state
);

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_T1 = 6'h02;
  localparam [5:0] ST_T2 = 6'h04;
  localparam [5:0] ST_T3 = 6'h08;
  localparam [5:0] ST_TW = 6'h10;
  localparam [5:0] ST_T4 = 6'h20;

  reg [5:0] state_reg;
  reg [5:0] state_next;
  reg [19:0] addr_reg;
  reg [19:0] op_addr_reg;
  reg [15:0] op_wdata_reg;
  reg op_write_reg;
  reg op_io_reg;
  reg op_word_reg;
  reg op_fetch_reg;
  reg op_second_reg;
  reg op_split_reg;
  reg discard_reg;
  reg [7:0] low_byte_reg;
  reg [19:0] pf_ptr_reg;
  reg [2:0] qcnt_reg;
  reg [7:0] q_mem [0:5];

  wire [`REQ_W-1:0] fifo_in;
  wire [`REQ_W-1:0] fifo_out;
  wire fifo_valid;
  wire f_write, f_io, f_word, f_vector;
  wire [19:0] f_addr;
  wire [15:0] f_wdata;

  // ****************************************************************
  // request fifo: the sequencer pops only when it starts a cycle
  // ****************************************************************
  assign fifo_in = {req_write, req_io, req_word, req_vector, req_addr,
    req_wdata};
  assign f_write = fifo_out[39];
  assign f_io = fifo_out[38];
  assign f_word = fifo_out[37];
  assign f_vector = fifo_out[36];
  assign f_addr = fifo_out[35:16];
  assign f_wdata = fifo_out[15:0];

  wire at_end, cont, room, take_fifo, start_pf, launch;

  req_fifo #(
    .WIDTH(`REQ_W),
    .DEPTH(`REQ_FIFO_DEPTH),
    .AW(`REQ_FIFO_AW)
  ) u_req_fifo (
    .clock(clock),
    .rstn(rstn),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(fifo_in),
    .out_valid(fifo_valid),
    .out_ready(take_fifo),
    .out_data(fifo_out)
  );

  // ****************************************************************
  // cycle arbitration: split halves, then requests, then prefetch
  // ****************************************************************
  assign at_end = state_reg[0] | state_reg[5];
  assign cont = state_reg[5] && op_split_reg && !op_second_reg;
  // wide bus refills only when a whole word is free
  assign room = wide_bus ? (qcnt_reg <= (`QUEUE_WIDE - 3'h2)) :
    (qcnt_reg < `QUEUE_NARROW);
  assign take_fifo = at_end && !cont && fifo_valid;
  assign start_pf = at_end && !cont && !fifo_valid && room &&
    !branch_valid;
  assign launch = cont || take_fifo || start_pf;

  reg [19:0] l_addr;
  reg [15:0] l_wdata;
  reg l_write;
  reg l_io;
  reg l_word;
  reg l_fetch;
  reg l_second;

  always @* begin
    l_addr = pf_ptr_reg;
    l_wdata = 16'h0000;
    l_write = 1'b0;
    l_io = 1'b0;
    // odd prefetch address fetches a lone byte, then words resume
    l_word = wide_bus && !pf_ptr_reg[0];
    l_fetch = 1'b1;
    l_second = 1'b0;
    if (cont) begin
      l_addr = op_addr_reg;
      l_wdata = op_wdata_reg;
      l_write = op_write_reg;
      l_io = op_io_reg;
      l_word = op_word_reg;
      l_fetch = op_fetch_reg;
      l_second = 1'b1;
    end else if (take_fifo) begin
      // vector table entries are words at even addresses
      l_addr = f_vector ? {f_addr[19:1], 1'b0} : f_addr;
      l_wdata = f_wdata;
      l_write = f_write && !f_vector;
      l_io = f_io && !f_vector;
      l_word = f_word || f_vector;
      l_fetch = 1'b0;
    end
  end

  wire [19:0] l_cyc_raw;
  wire [19:0] l_cyc;
  wire l_ube_n;
  wire [15:0] l_lane;
  wire l_split;

  assign l_cyc_raw = l_second ? (l_addr + `ADDR_STEP) : l_addr;
  // io addresses skip segment bases; upper four lines forced low
  assign l_cyc = l_io ? (l_cyc_raw & `IO_ADDR_MASK) : l_cyc_raw;

  // io word split follows the same lane rules as memory
  lane_steer u_lane_steer (
    .wide_bus(wide_bus),
    .cycle_a0(l_cyc[0]),
    .word(l_word),
    .second(l_second),
    .wdata(l_wdata),
    .upper_lane_select_n(l_ube_n),
    .lane_data(l_lane),
    .split(l_split)
  );

  // ****************************************************************
  // state sequencing
  // ****************************************************************
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: state_next = launch ? ST_T1 : ST_IDLE;
      ST_T1: state_next = ST_T2;
      ST_T2: state_next = ST_T3;
      ST_T3: state_next = ready ? ST_T4 : ST_TW;
      ST_TW: state_next = ready ? ST_T4 : ST_TW;
      ST_T4: state_next = launch ? ST_T1 : ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  wire sample;
  wire [7:0] rbyte;
  wire word_beat;
  wire flush;
  wire take;
  wire push;
  wire push2;
  wire [2:0] base;

  // ready is looked at once per third or wait state edge
  assign sample = (state_reg[3] | state_reg[4]) && ready;
  assign rbyte = (wide_bus && addr_reg[0]) ? data_in[15:8] : data_in[7:0];
  assign word_beat = wide_bus && op_word_reg && !op_split_reg;
  assign flush = branch_valid;
  assign take = q_take && q_valid && !flush;
  assign push = sample && op_fetch_reg && !discard_reg && !flush;
  assign push2 = push && word_beat;
  assign base = qcnt_reg - {2'b00, take};

  // ****************************************************************
  // bus pins: loaded entering the first state, held through waits
  // ****************************************************************
  assign bus_addr = addr_reg[19:1];
  assign address_bit_zero = addr_reg[0];
  assign first_bus_state = state_reg[1];
  assign fourth_bus_state = state_reg[5];
  assign bus_wait_state = state_reg[4];
  assign bus_idle_state = state_reg[0];

  always @(posedge clock) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      addr_reg <= 20'h0_0000;
      upper_lane_select_n <= 1'b1;
      data_out <= 16'h0000;
      data_oe <= 1'b0;
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      io_cycle <= 1'b0;
    end else begin
      state_reg <= state_next;
      // in the wait state only the ready-high release of rd_n and wr_n is assigned; every other pin holds
      if (launch) begin
        addr_reg <= l_cyc;
        upper_lane_select_n <= l_ube_n;
        data_out <= l_lane;
        // back-to-back cycles still get the fourth-state release of the data lanes
        data_oe <= 1'b0;
        ale <= 1'b1;
        // memory-mapped io sees plain memory strobes
        io_cycle <= l_io;
      end else if (state_reg[1]) begin
        ale <= 1'b0;
        rd_n <= op_write_reg;
        wr_n <= !op_write_reg;
        data_oe <= op_write_reg;
      end else if (sample) begin
        rd_n <= 1'b1;
        wr_n <= 1'b1;
      end else if (state_reg[5]) begin
        upper_lane_select_n <= 1'b1;
        data_oe <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // operation tracking and read assembly
  // ****************************************************************
  always @(posedge clock) begin
    if (!rstn) begin
      op_addr_reg <= 20'h0_0000;
      op_wdata_reg <= 16'h0000;
      op_write_reg <= 1'b0;
      op_io_reg <= 1'b0;
      op_word_reg <= 1'b0;
      op_fetch_reg <= 1'b0;
      op_second_reg <= 1'b0;
      op_split_reg <= 1'b0;
      discard_reg <= 1'b0;
      low_byte_reg <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      if (launch) begin
        op_addr_reg <= l_addr;
        op_wdata_reg <= l_wdata;
        op_write_reg <= l_write;
        op_io_reg <= l_io;
        op_word_reg <= l_word;
        op_fetch_reg <= l_fetch;
        op_second_reg <= l_second;
        op_split_reg <= l_split;
        discard_reg <= l_second && discard_reg;
      end else if (flush) begin
        // a fetch already on the bus belongs to the old stream
        discard_reg <= 1'b1;
      end
      if (sample && !op_fetch_reg) begin
        if (op_split_reg && !op_second_reg) begin
          low_byte_reg <= rbyte;
        end else begin
          rsp_valid <= 1'b1;
          if (op_split_reg) begin
            rsp_data <= {rbyte, low_byte_reg};
          end else if (word_beat) begin
            rsp_data <= data_in;
          end else begin
            rsp_data <= {8'h00, rbyte};
          end
        end
      end
    end
  end

  // ****************************************************************
  // prefetch pointer and queue; branch clears queue and reloads
  // ****************************************************************
  assign q_valid = (qcnt_reg != 3'h0) && !flush;
  assign q_byte = q_mem[0];

  always @(posedge clock) begin
    if (!rstn) begin
      pf_ptr_reg <= 20'h0_0000;
      qcnt_reg <= 3'h0;
    end else if (flush) begin
      pf_ptr_reg <= branch_addr;
      qcnt_reg <= 3'h0;
    end else begin
      if (push) begin
        pf_ptr_reg <= pf_ptr_reg + {18'h0_0000, push2, !push2};
      end
      qcnt_reg <= base + {1'b0, push2, push && !push2};
    end
  end

  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : g_queue
      localparam [2:0] IDX = i;
      always @(posedge clock) begin
        if (push && base == IDX) begin
          q_mem[i] <= push2 ? data_in[7:0] : rbyte;
        end else if (push2 && base + 3'h1 == IDX) begin
          q_mem[i] <= data_in[15:8];
        end else if (take) begin
          if (i < 5) begin
            q_mem[i] <= q_mem[(i < 5) ? i + 1 : i];
          end else begin
            q_mem[i] <= 8'h00;
          end
        end
      end
    end
  endgenerate

endmodule // bus_unit

// >>> tb/bus_unit_props.sv
// concurrent checks on the bus unit's pins
// assumes the one clock and synchronous active-low reset of bus_unit
module bus_unit_props (
  input logic clock,
  input logic rstn,
  input logic wide_bus,
  input logic ready,
  input logic [19:1] bus_addr,
  input logic address_bit_zero,
  input logic upper_lane_select_n,
  input logic [15:0] data_out,
  input logic data_oe,
  input logic ale,
  input logic rd_n,
  input logic wr_n,
  input logic io_cycle,
  input logic rsp_valid,
  input logic first_bus_state,
  input logic fourth_bus_state,
  input logic bus_wait_state,
  input logic bus_idle_state
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // bus cycle checks
  // ****************************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_strobe_on;
    !ale && (!rd_n || !wr_n);
  endsequence
  sequence s_late_state;
    fourth_bus_state || bus_wait_state;
  endsequence
  chk_four_states: assert property (
    first_bus_state |-> ##1 s_strobe_on ##2 s_late_state)
    else $error("bus cycle did not follow four states");
  chk_wait_hold: assert property (bus_wait_state |->
    $stable({bus_addr, address_bit_zero, upper_lane_select_n, data_out,
    data_oe, rd_n, wr_n, io_cycle}))
    else $error("bus outputs moved in a wait state");
  chk_ready_release: assert property (
    bus_wait_state && ready |=> fourth_bus_state)
    else $error("ready high did not end the wait");
  chk_ready_hold: assert property (
    bus_wait_state && !ready |=> bus_wait_state)
    else $error("wait ended while ready low");
  chk_io_top_zero: assert property (
    io_cycle |-> bus_addr[19:16] == 4'h0)
    else $error("io cycle with upper address lines set");
  chk_narrow_upper: assert property (
    !wide_bus |-> upper_lane_select_n)
    else $error("narrow bus drove the upper lane");
  chk_lane_select: assert property (
    wide_bus && first_bus_state |-> !(upper_lane_select_n && address_bit_zero))
    else $error("cycle selected no bank");
  chk_rsp_at_end: assert property (
    rsp_valid |-> fourth_bus_state)
    else $error("response outside the fourth state");
  chk_idle_quiet: assert property (
    bus_idle_state |-> rd_n && wr_n && !ale && !data_oe)
    else $error("bus active during idle state");
  chk_cycle_exit: assert property (
    fourth_bus_state |-> rd_n && wr_n ##1 (first_bus_state || bus_idle_state))
    else $error("fourth state not followed by first or idle");
endmodule // bus_unit_props

bind bus_unit bus_unit_props bus_unit_props_inst (.clock(clock), .rstn(rstn),
  .wide_bus(wide_bus), .ready(ready), .bus_addr(bus_addr),
  .address_bit_zero(address_bit_zero), .data_oe(data_oe),
  .upper_lane_select_n(upper_lane_select_n), .data_out(data_out),
  .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .io_cycle(io_cycle),
  .rsp_valid(rsp_valid), .first_bus_state(first_bus_state),
  .fourth_bus_state(fourth_bus_state), .bus_wait_state(bus_wait_state),
  .bus_idle_state(bus_idle_state));

// >>> tb/mem_partner.sv
// byte memory standing on the far side of the bus unit
// assumes strobes and lane selects come straight from bus_unit
module mem_partner (
  input logic clock,
  input logic wide_bus,
  input logic [19:1] bus_addr,
  input logic address_bit_zero,
  input logic upper_lane_select_n,
  input logic [15:0] data_out,
  input logic rd_n,
  input logic wr_n,
  input logic [3:0] wait_n,
  output logic [15:0] data_in,
  output logic ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // memory banks
  // ****************************************************************
  logic [7:0] mem [0:511];
  logic [3:0] cnt_reg = 4'h0;
  logic [15:0] last_reg = 16'h0000;
  logic [8:0] a;
  assign a = {bus_addr[8:1], address_bit_zero};
  initial for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'h5a;
  // slow device keeps ready low until its count runs out
  assign ready = (rd_n && wr_n) || cnt_reg > wait_n;
  // released bus shows the inverse of the last value, not a held copy
  assign data_in = rd_n ? ~last_reg : wide_bus ?
    {mem[{a[8:1], 1'b1}], mem[{a[8:1], 1'b0}]} : {~last_reg[15:8], mem[a]};
  always @(posedge clock) begin
    cnt_reg <= (rd_n && wr_n) ? 4'h0 : cnt_reg + 4'h1;
    if (!rd_n) last_reg <= data_in;
    if (!wr_n && ready) begin
      if (!wide_bus) mem[a] <= data_out[7:0];
      else begin
        // low bank by bit zero, high bank by lane select
        if (!address_bit_zero) mem[{a[8:1], 1'b0}] <= data_out[7:0];
        if (!upper_lane_select_n) mem[{a[8:1], 1'b1}] <= data_out[15:8];
      end
    end
  end
endmodule // mem_partner

// >>> tb/cpu_bus_cycle_lane_steering_tb.sv
// scenario bench for bus_unit with a memory partner
// assumes 100 mhz clock; bus cycles recorded at each fourth state
module cpu_bus_cycle_lane_steering_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rstn = 0, wide_bus = 1, req_valid = 0, req_write = 0;
  logic req_io = 0, req_word = 0, req_vector = 0, branch_valid = 0;
  logic q_take = 0;
  logic [19:0] req_addr = 0, branch_addr = 0;
  logic [15:0] req_wdata = 0;
  logic [3:0] wait_n = 0;
  wire req_ready, rsp_valid, q_valid, address_bit_zero, upper_lane_select_n;
  wire data_oe, ale, rd_n, wr_n, io_cycle, ready, first_bus_state;
  wire fourth_bus_state, bus_wait_state, bus_idle_state;
  wire [15:0] rsp_data, data_out, data_in;
  wire [7:0] q_byte;
  wire [19:1] bus_addr;
  int err_total = 0, compares = 0, waits = 0;
  logic [19:0] c_addr [$];
  logic c_ube [$], c_io [$];
  logic [15:0] c_dat [$];
  bus_unit bus_unit_inst (.clock(clock), .rstn(rstn), .wide_bus(wide_bus),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_io(req_io), .req_word(req_word), .req_vector(req_vector),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .branch_valid(branch_valid),
    .branch_addr(branch_addr), .q_byte(q_byte), .q_valid(q_valid),
    .q_take(q_take), .bus_addr(bus_addr), .address_bit_zero(address_bit_zero),
    .upper_lane_select_n(upper_lane_select_n), .data_out(data_out),
    .data_oe(data_oe), .data_in(data_in), .ale(ale), .rd_n(rd_n),
    .wr_n(wr_n), .io_cycle(io_cycle), .ready(ready),
    .first_bus_state(first_bus_state), .fourth_bus_state(fourth_bus_state),
    .bus_wait_state(bus_wait_state), .bus_idle_state(bus_idle_state));
  mem_partner mem_partner_inst (.clock(clock), .wide_bus(wide_bus),
    .bus_addr(bus_addr), .address_bit_zero(address_bit_zero),
    .upper_lane_select_n(upper_lane_select_n), .data_out(data_out),
    .rd_n(rd_n), .wr_n(wr_n), .wait_n(wait_n), .data_in(data_in),
    .ready(ready));
  // ****************************************************************
  // clock, monitor and shared tasks
  // ****************************************************************
  always #5 clock = ~clock;
  always @(posedge clock) begin
    if (bus_wait_state) waits++;
    if (fourth_bus_state) begin
      c_addr.push_back({bus_addr, address_bit_zero});
      c_ube.push_back(upper_lane_select_n);
      c_dat.push_back(data_out);
      c_io.push_back(io_cycle);
    end
  end
  task automatic wrap_up;
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic clr;
    // a fetch still on the bus would land in the fresh record otherwise
    for (int t = 0; t < 60 && bus_idle_state !== 1'b1; t++) tick(1);
    c_addr.delete();
    c_ube.delete();
    c_dat.delete();
    c_io.delete();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic access(input logic w, io, wd, vec, input logic [19:0] ad,
    input logic [15:0] dat);
    int n;
    n = 0;
    req_valid = 1;
    {req_write, req_io, req_word, req_vector} = {w, io, wd, vec};
    req_addr = ad;
    req_wdata = dat;
    while (req_ready !== 1'b1 && n < 100) begin tick(1); n++; end
    tick(1);
    req_valid = 0;
    req_vector = 0;
    while (rsp_valid !== 1'b1 && n < 300) begin tick(1); n++; end
    chk(rsp_valid, 1);
    tick(1);
  endtask
  task automatic do_reset;
    rstn = 0;
    tick(6);
    chk(bus_idle_state & upper_lane_select_n & rd_n & wr_n, 1);
    rstn = 1;
    tick(60);
    chk(bus_idle_state, 1);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic lanes_wide;
    logic [19:0] ad [4] = '{20'h0_0010, 20'h0_0021, 20'h0_0032, 20'h0_0043};
    for (int k = 0; k < 4; k++) begin
      clr();
      access(1, 0, k < 2, 0, ad[k], 16'hc3a5);
      chk(c_addr.size(), (k == 1) ? 2 : 1);
      chk(c_addr[0], ad[k]);
      chk(c_ube[0], k == 2);
      if (ad[k][0]) chk(c_dat[0][15:8], 8'ha5);
      else chk(c_dat[0][7:0], 8'ha5);
      if (k == 0) chk(c_dat[0][15:8], 8'hc3);
      if (k == 1) chk({c_addr[1], c_ube[1], c_dat[1][7:0]},
        {20'h0_0022, 1'b1, 8'hc3});
    end
    access(0, 0, 1, 0, 20'h0_0021, 0);
    chk(rsp_data, 16'hc3a5);
    access(0, 0, 0, 0, 20'h0_0043, 0);
    chk(rsp_data, 16'h00a5);
  endtask
  // io addresses keep only the low 16 lines; the upper four are forced to zero
  task automatic io_space;
    clr();
    access(1, 1, 1, 0, 20'ha_12fd, 16'h7e81);
    chk(c_addr.size(), 2);
    chk(c_addr[0], 20'h0_12fd);
    chk(c_addr[1], 20'h0_12fe);
    chk(c_io[0], 1);
    clr();
    access(1, 1, 1, 0, 20'h0_4a40, 16'h1234);
    chk(c_addr.size(), 1);
    clr();
    access(1, 0, 0, 0, 20'h0_0050, 16'h0011);
    chk(c_io[0], 0);
    clr();
    access(0, 0, 1, 1, 20'h0_0021, 0);
    chk(c_addr.size(), 1);
    chk(c_addr[0], 20'h0_0020);
  endtask
  task automatic wait_states;
    wait_n = 4'h3;
    waits = 0;
    access(0, 0, 1, 0, 20'h0_0010, 0);
    chk(waits, 3);
    chk(rsp_data, 16'hc3a5);
    wait_n = 4'h0;
  endtask
  task automatic prefetch(input logic [19:0] br, input int n);
    int t;
    clr();
    branch_valid = 1;
    branch_addr = br;
    tick(1);
    branch_valid = 0;
    tick(60);
    chk(c_addr.size(), n);
    chk(c_ube[0], !wide_bus);
    chk(c_addr[1], br + ((wide_bus && !br[0]) ? 2 : 1));
    chk(bus_idle_state, 1);
    for (int k = 0; k < 6; k++) begin
      t = 0;
      while (q_valid !== 1'b1 && t < 50) begin tick(1); t++; end
      chk(q_byte, (br[7:0] + k[7:0]) ^ 8'h5a);
      q_take = 1;
      tick(1);
      q_take = 0;
    end
  endtask
  task automatic fifo_fill;
    int acc, got, n;
    {wait_n, acc, got} = {4'h8, 32'd0, 32'd0};
    {req_valid, req_write, req_word, req_addr} = {3'b110, 20'h0_0070};
    for (n = 0; n < 60 && req_ready === 1'b1; n++) begin
      tick(1);
      acc++;
      if (rsp_valid === 1'b1) got++;
    end
    req_valid = 0;
    chk(req_ready, 0);
    chk(acc >= 32 && acc < 40, 1);
    for (n = 0; n < 2000 && got < acc; n++) begin
      tick(1);
      if (rsp_valid === 1'b1) got++;
    end
    chk(got, acc);
    wait_n = 4'h0;
  endtask
  task automatic narrow_word;
    clr();
    access(1, 0, 1, 0, 20'h0_0060, 16'hbeef);
    chk(c_addr.size(), 2);
    chk({c_addr[1], c_dat[0][7:0], c_dat[1][7:0]},
      {20'h0_0061, 8'hef, 8'hbe});
  endtask
  initial begin
    tick(1);
    do_reset();
    lanes_wide();
    io_space();
    wait_states();
    prefetch(20'h1_0101, 3);
    prefetch(20'h0_0180, 3);
    fifo_fill();
    wide_bus = 0;
    do_reset();
    prefetch(20'h0_0180, 4);
    narrow_word();
    wrap_up();
  end
endmodule // cpu_bus_cycle_lane_steering_tb
